// ===== asc_ctrl.v
/*
  register bank for sync gating, output-enable pin gating, low-rate
  oscillator control, overrange pin enable and output channel assignment.
  assumes a serial port front end that presents parallel writes and reads
  synchronous to clk_sys, a sync pulse and low-rate flag already in clk_sys.
*/
`timescale 1ns/1ns
`default_nettype none
`include "asc_map.vh"

// Behaviour
// - no sync action happens unless master sync enable bit is high.
// - divider sync enable bit gates sync pulses reaching clock divider.
// - with bits 1,0 high and bit 2 low, resync divider every pulse.
// - in next-sync-only mode, divider aligns to first pulse, ignores later.
// - after next-sync-only sync, hardware clears divider sync enable bit.
// - output-enable pin honoured only when user control two bit 7 high.
// - with detect enabled, low encode rate starts internal oscillator.
// - detect bit cleared disables detector's automatic oscillator start.
// - run bit forces internal oscillator on regardless of detector.
// - pull-down bit high removes serial data pin pull-down.
module asc_ctrl (
  input  wire                    clk_sys,
  input  wire                    rst_b,
  input  wire                    reg_wr,
  input  wire                    reg_rd,
  input  wire [`ASC_ADDR_W-1:0]  reg_addr,
  input  wire [7:0]              reg_wdata,
  input  wire [`ASC_NUM_CH-1:0]  ch_index,
  output reg  [7:0]              reg_rdata,
  output wire                    reg_ack,
  output wire                    reg_err,
  input  wire                    sync_in,
  input  wire                    low_rate_seen,
  input  wire                    output_enable_pin_active_low,
  output reg                     div_sync_pulse,
  output reg                     outputs_enabled,
  output reg                     low_rate_internal_oscillator,
  output reg                     sdio_pulldown_on,
  output reg  [`ASC_NUM_CH-1:0]  overrange_pin_en,
  output reg  [`ASC_NUM_CH-1:0]  channel_source_b
);

  reg  [7:0]             sync_control;
  reg  [7:0]             user_control_two;
  reg  [`ASC_NUM_CH-1:0] ovr_bit;
  reg  [`ASC_NUM_CH-1:0] assign_bit;
  wire                   sync_fire;
  wire                   hit_sync;
  wire                   hit_uct2;
  wire                   hit_ovr;
  wire                   hit_asg;

  function is_addr;
    input [`ASC_ADDR_W-1:0] a;
    input [`ASC_ADDR_W-1:0] ofs;
    begin
      is_addr = (a == ofs);
    end
  endfunction

  assign hit_sync = is_addr(reg_addr, `ASC_OFS_SYNC);
  assign hit_uct2 = is_addr(reg_addr, `ASC_OFS_UCT2);
  assign hit_ovr  = is_addr(reg_addr, `ASC_OFS_OVR_PIN);
  assign hit_asg  = is_addr(reg_addr, `ASC_OFS_OUT_ASSIGN);
  assign reg_ack  = reg_wr | reg_rd;
  // unmapped access is acknowledged but flagged; reads return zero
  assign reg_err  = reg_ack & ~(hit_sync | hit_uct2 | hit_ovr | hit_asg);

  // pulse reaches divider only through both enables
  assign sync_fire = sync_in & sync_control[`ASC_BIT_MASTER]
                   & sync_control[`ASC_BIT_DIV_SYNC];

  // hardware clear wins over a host write in the same cycle, so the
  // one-shot cannot be re-armed by a write racing the pulse
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sync_control <= `ASC_RST_SYNC;
    end else if (sync_fire && sync_control[`ASC_BIT_NEXT_ONLY]) begin
      sync_control[`ASC_BIT_DIV_SYNC] <= 1'b0;
    end else if (reg_wr && hit_sync) begin
      sync_control <= reg_wdata & `ASC_MASK_SYNC;
    end
  end

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      user_control_two <= `ASC_RST_UCT2;
      div_sync_pulse   <= 1'b0;
    end else begin
      if (reg_wr && hit_uct2) begin
        user_control_two <= reg_wdata & `ASC_MASK_UCT2;
      end
      div_sync_pulse <= sync_fire;
    end
  end

  genvar g;
  generate
    for (g = 0; g < `ASC_NUM_CH; g = g + 1) begin : g_ch
      always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          ovr_bit[g]    <= `ASC_RST_OVR_OE;
          assign_bit[g] <= (g == 0) ? `ASC_RST_SRC_A : `ASC_RST_SRC_B;
        end else begin
          if (reg_wr && hit_ovr && ch_index[g]) begin
            ovr_bit[g] <= reg_wdata[`ASC_BIT_OVR_OE];
          end
          if (reg_wr && hit_asg && ch_index[g]) begin
            assign_bit[g] <= reg_wdata[`ASC_BIT_ASSIGN];
          end
        end
      end
    end
  endgenerate

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      outputs_enabled              <= 1'b1;
      low_rate_internal_oscillator <= 1'b0;
      sdio_pulldown_on             <= 1'b1;
      overrange_pin_en             <= {`ASC_NUM_CH{1'b1}};
      channel_source_b             <= {`ASC_NUM_CH{1'b0}};
    end else begin
      outputs_enabled  <= ~(user_control_two[`ASC_BIT_OE_PIN_EN]
                          & output_enable_pin_active_low);
      low_rate_internal_oscillator <= user_control_two[`ASC_BIT_RUN_OSC]
        | (user_control_two[`ASC_BIT_DET_EN] & low_rate_seen);
      sdio_pulldown_on <= ~user_control_two[`ASC_BIT_PD_OFF];
      overrange_pin_en <= ovr_bit;
      channel_source_b <= assign_bit;
    end
  end

  // read data: first indexed channel answers for local registers
  always @* begin
    reg_rdata = `ASC_ZERO8;
    if (reg_rd) begin
      if (hit_sync) begin
        reg_rdata = sync_control;
      end else if (hit_uct2) begin
        reg_rdata = user_control_two;
      end else if (hit_ovr) begin
        reg_rdata = {7'h00, (ch_index[0] ? ovr_bit[0] : ovr_bit[1])};
      end else if (hit_asg) begin
        reg_rdata = {7'h00, (ch_index[0] ? assign_bit[0] : assign_bit[1])};
      end
    end
  end

endmodule
`default_nettype wire

// ===== asc_map.vh
/*
  register offsets, field positions, reset values, write masks and channel count
  for the converter sync and miscellaneous control register bank.
  assumes inclusion by asc_ctrl.v only; definitions only.
*/
`ifndef ASC_MAP_VH
`define ASC_MAP_VH

`define ASC_ADDR_W          13
`define ASC_OFS_OVR_PIN     13'h002A
`define ASC_OFS_OUT_ASSIGN  13'h002E
`define ASC_OFS_SYNC        13'h0100
`define ASC_OFS_UCT2        13'h0101

`define ASC_RST_OVR_PIN     8'h01
`define ASC_RST_ASSIGN_A    8'h00
`define ASC_RST_ASSIGN_B    8'h01
`define ASC_RST_SYNC        8'h01
`define ASC_RST_UCT2        8'h88
`define ASC_RST_OVR_OE      1'b1
`define ASC_RST_SRC_A       1'b0
`define ASC_RST_SRC_B       1'b1
`define ASC_ZERO8           8'h00

`define ASC_BIT_OVR_OE      0
`define ASC_BIT_ASSIGN      0
`define ASC_BIT_MASTER      0
`define ASC_BIT_DIV_SYNC    1
`define ASC_BIT_NEXT_ONLY   2
`define ASC_BIT_OE_PIN_EN   7
`define ASC_BIT_DET_EN      3
`define ASC_BIT_RUN_OSC     2
`define ASC_BIT_PD_OFF      0
`define ASC_MASK_SYNC       8'h07
`define ASC_MASK_UCT2       8'h8D
`define ASC_MASK_BIT0       8'h01

`define ASC_NUM_CH          2

`endif

// ===== asc_ctrl_monitor.sv
/* port checker for asc_ctrl; bound to every instance, one clock */
`timescale 1ns/1ns
`default_nettype none
module asc_ctrl_monitor (
  input wire logic        clk_sys, rst_b, reg_wr, reg_rd, reg_ack, reg_err, sync_in,
  input wire logic        div_sync_pulse, outputs_enabled, sdio_pulldown_on,
  input wire logic        low_rate_internal_oscillator,
  input wire logic [12:0] reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic [1:0]  ch_index, overrange_pin_en, channel_source_b
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  wire logic u2 = reg_wr && reg_addr == 13'h0101;
  wire logic ab = reg_wr && reg_addr == 13'h002A && ch_index == 2'h3;
  wire logic oa = reg_wr && reg_addr == 13'h002E && ch_index == 2'h1;
  a_sync_cause: assert property (div_sync_pulse |-> $past(sync_in))
    else $error("stray sync");
  a_ack_tracks: assert property (reg_ack == (reg_wr || reg_rd)) else $error("bad ack");
  a_err_acked: assert property (reg_err |-> reg_ack) else $error("bad err");
  a_osc_forced: assert property (u2 && reg_wdata[2] |=> ##1 low_rate_internal_oscillator)
    else $error("osc off");
  a_pd_follows: assert property (u2 |=> ##1 sdio_pulldown_on != $past(reg_wdata[0], 2))
    else $error("bad pulldown");
  a_oe_ignored: assert property (u2 && !reg_wdata[7] |=> ##1 outputs_enabled)
    else $error("pin used");
  a_ovr_both: assert property (ab |=> ##1 overrange_pin_en == {2{$past(reg_wdata[0], 2)}})
    else $error("bad overrange");
  a_src_chan: assert property (oa |=> ##1 channel_source_b[0] == $past(reg_wdata[0], 2))
    else $error("bad source");
  c_sync: cover property (div_sync_pulse);
  c_err: cover property (reg_err);
  c_osc: cover property (low_rate_internal_oscillator);
endmodule
bind asc_ctrl asc_ctrl_monitor u_asc_ctrl_monitor (.*);
`default_nettype wire

// ===== asc_host_model.sv
/* serial port host model; drives strobes on the falling edge of clk_sys */
`timescale 1ns/1ns
`default_nettype none
module asc_host_model (
  input  wire logic        clk_sys,
  input  wire logic [7:0]  reg_rdata,
  output var  logic        reg_wr, reg_rd, sync_in,
  output var  logic [12:0] reg_addr,
  output var  logic [7:0]  reg_wdata
);
  initial {reg_wr, reg_rd, sync_in, reg_addr, reg_wdata} = 24'h0;
  // strobes drop right after each access, so the port idles
  task acc(input logic w, input logic [12:0] a, input logic [7:0] d, output logic [7:0] q);
    @(negedge clk_sys);
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
    @(posedge clk_sys);
    q = reg_rdata;
    @(negedge clk_sys);
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {2'h0, ~a, ~d};
  endtask
  task pulse;
    @(negedge clk_sys);
    sync_in = 1'h1;
    @(negedge clk_sys);
    sync_in = 1'h0;
  endtask
endmodule
`default_nettype wire

// ===== asc_ctrl_tb.sv
/* self-checking bench for asc_ctrl; host model issues register and sync traffic */
`timescale 1ns/1ns
`default_nettype none
module asc_ctrl_tb;
  logic             clk_sys, rst_b, low_rate_seen, output_enable_pin_active_low;
  logic [1:0]       ch_index;
  logic [7:0]       errors, total_checks, npulse, q;
  wire logic        reg_wr, reg_rd, sync_in, reg_ack, reg_err, div_sync_pulse;
  wire logic        outputs_enabled, low_rate_internal_oscillator, sdio_pulldown_on;
  wire logic [12:0] reg_addr;
  wire logic [7:0]  reg_wdata, reg_rdata;
  wire logic [1:0]  overrange_pin_en, channel_source_b;
  asc_ctrl u_asc_ctrl (.*);
  asc_host_model u_asc_host_model (.*);
  initial begin
    clk_sys = 1'h0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys or negedge rst_b)
    if (!rst_b) npulse <= 8'h00;
    else if (div_sync_pulse) npulse <= npulse + 8'h1;
  task chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks = total_checks + 8'h1;
    if (got !== exp) begin
      errors = errors + 8'h1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [12:0] a, input logic [7:0] d);
    u_asc_host_model.acc(1'h1, a, d, q);
  endtask
  task rc(input logic [12:0] a, input logic [7:0] e);
    u_asc_host_model.acc(1'h0, a, 8'h00, q);
    chk(q, e);
  endtask
  // one edge lets registered outputs settle
  task st(input logic [7:0] e);
    @(negedge clk_sys);
    chk({1'h0, outputs_enabled, low_rate_internal_oscillator, sdio_pulldown_on,
         overrange_pin_en, channel_source_b}, e);
  endtask
  task tally_and_finish;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 8'h00 && total_checks != 8'h00)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    {rst_b, low_rate_seen, output_enable_pin_active_low} = 3'h0;
    ch_index = 2'h3;
    errors = 8'h00;
    total_checks = 8'h00;
    repeat (12) @(negedge clk_sys);
    rst_b = 1'h1;
    st(8'h5E);
    rc(13'h0100, 8'h01);
    rc(13'h0101, 8'h88);
    ch_index = 2'h1;
    rc(13'h002E, 8'h00);
    ch_index = 2'h2;
    rc(13'h002E, 8'h01);
    rc(13'h002A, 8'h01);
    wr(13'h0100, 8'h02);
    u_asc_host_model.pulse;
    wr(13'h0100, 8'h01);
    u_asc_host_model.pulse;
    wr(13'h0100, 8'h03);
    chk(npulse, 8'h00);
    repeat (2) u_asc_host_model.pulse;
    wr(13'h0100, 8'h07);
    repeat (2) u_asc_host_model.pulse;
    rc(13'h0100, 8'h05);
    chk(npulse, 8'h03);
    output_enable_pin_active_low = 1'h1;
    st(8'h1E);
    wr(13'h0101, 8'h7F);
    st(8'h6E);
    rc(13'h0101, 8'h0D);
    {low_rate_seen, output_enable_pin_active_low} = 2'h2;
    wr(13'h0101, 8'h88);
    st(8'h7E);
    wr(13'h0101, 8'h80);
    st(8'h5E);
    ch_index = 2'h1;
    wr(13'h002A, 8'h00);
    wr(13'h002E, 8'h01);
    st(8'h5B);
    ch_index = 2'h3;
    wr(13'h002A, 8'h01);
    st(8'h5F);
    wr(13'h0055, 8'hFF);
    rc(13'h0055, 8'h00);
    tally_and_finish;
  end
endmodule
`default_nettype wire
